// ==== verilog/blspc_pkg.sv ====
// Package with register map, field layout and timing for the self-program control block
package blspc_pkg;
  localparam logic [11:0] BLSPC_OFS_CTRL    = 12'h000;
  localparam logic [11:0] BLSPC_OFS_PTR     = 12'h004;
  localparam logic [11:0] BLSPC_OFS_DATA    = 12'h008;
  localparam logic [11:0] BLSPC_OFS_ISSUE   = 12'h00C;
  localparam logic [11:0] BLSPC_OFS_LOCK    = 12'h010;
  localparam logic [11:0] BLSPC_OFS_STATUS  = 12'h014;
  localparam logic [11:0] BLSPC_OFS_LATADDR = 12'h018;
  localparam logic [11:0] BLSPC_OFS_RDDATA  = 12'h01C;
  localparam logic [7:0] BLSPC_CMD_ERASE    = 8'h03;
  localparam logic [7:0] BLSPC_CMD_FILL     = 8'h01;
  localparam logic [7:0] BLSPC_CMD_WRITE    = 8'h05;
  localparam logic [7:0] BLSPC_CMD_LOCK     = 8'h09;
  localparam logic [7:0] BLSPC_CMD_MASK     = 8'h7F;
  localparam int BLSPC_WINDOW_CLK           = 4;
  localparam logic [2:0] BLSPC_WINDOW_CYC   = 3'(BLSPC_WINDOW_CLK);
  localparam logic [1:0] BLSPC_LOCK_RST     = 2'h3;
  localparam logic [15:0] BLSPC_APP_VEC     = 16'h0000;
  localparam int BLSPC_ISSUE_LPM_BIT        = 0;
  localparam int BLSPC_ISSUE_BOOT_BIT       = 1;
  localparam int BLSPC_ISSUE_SPM_BIT        = 2;
  localparam int BLSPC_ISSUE_INTV_BIT       = 3;
  localparam int BLSPC_LKD_APP_LO_BIT       = 2;
  localparam int BLSPC_LKD_APP_HI_BIT       = 3;
  localparam int BLSPC_LKD_BOOT_LO_BIT      = 4;
  localparam int BLSPC_LKD_BOOT_HI_BIT      = 5;
  typedef enum logic [1:0] {BLSPC_IDLE = 2'b00, BLSPC_ARMED = 2'b01} blspc_state_t;
endpackage : blspc_pkg

// ==== verilog/blspc_top.sv ====
// Boot lock decode, pointer latch and self-program sequencing with an APB slave
`timescale 1ns/1ps
`default_nettype none
module blspc_top
  import blspc_pkg::*;
#(
  parameter int WORD_BITS = 6,
  parameter int ADDR_BITS = 15,
  parameter logic [15:0] BOOT_START = 16'h7000
)(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        chip_erase,
  input  wire logic        boot_reset_fuse,
  output logic [15:0]      reset_vector,
  output logic             int_mask,
  output logic             flash_erase,
  output logic             flash_fill,
  output logic             flash_write,
  output logic             flash_read,
  output logic [15:0]      flash_addr,
  output logic [15:0]      flash_wdata,
  input  wire logic [7:0]  flash_rbyte
);
  logic [7:0]  ctrl_r;
  logic [7:0]  pointer_high_byte;
  logic [7:0]  pointer_low_byte;
  logic [15:0] data_r;
  logic        app_lock_bit_hi;
  logic        app_lock_bit_lo;
  logic        boot_lock_bit_hi;
  logic        boot_lock_bit_lo;
  logic [1:0]  app_lock_field;
  logic [1:0]  boot_lock_field;
  logic [2:0]  win_r;
  blspc_state_t state_r;
  logic [15:0] lat_addr_r;
  logic [7:0]  rd_byte_r;
  logic [1:0]  drop_cnt_r;
  logic        fuse_s1_r;
  logic        fuse_s2_r;
  logic        ce_s1_r;
  logic        ce_s2_r;
  logic        intv_boot_r;
  logic        exec_boot_r;
  logic        wr_acc;
  logic        spm_go;
  logic        drop_evt;
  logic        issue;
  logic        is_spm;
  logic        is_lpm;
  logic        from_boot;
  logic [15:0] ptr;
  logic        tgt_boot;
  logic        spm_ok;
  logic        lpm_ok;
  logic        map_hit;
  logic [7:0]  cmd;
  assign wr_acc = psel && penable && pwrite;
  assign issue  = wr_acc && paddr == BLSPC_OFS_ISSUE;
  assign is_spm = issue && pwdata[BLSPC_ISSUE_SPM_BIT];
  assign is_lpm = issue && pwdata[BLSPC_ISSUE_LPM_BIT];
  assign from_boot = pwdata[BLSPC_ISSUE_BOOT_BIT];
  assign ptr = {pointer_high_byte, pointer_low_byte};
  assign tgt_boot = ptr >= BOOT_START;
  assign app_lock_field  = {app_lock_bit_hi, app_lock_bit_lo};
  assign boot_lock_field = {boot_lock_bit_hi, boot_lock_bit_lo};
  assign cmd = ctrl_r & BLSPC_CMD_MASK;
  assign spm_go = is_spm && pready && from_boot && state_r == BLSPC_ARMED;
  // Write permission: bit lo programmed means no store-program erase or write; general lock modes not consulted
  // Cross-section read blocked when bit hi programmed
  always_comb
  begin
    spm_ok = app_lock_bit_lo;
    lpm_ok = !from_boot || app_lock_bit_hi;
    if (tgt_boot)
    begin
      spm_ok = boot_lock_bit_lo;
      lpm_ok = from_boot || boot_lock_bit_hi;
    end
  end

  // Register map decode
  always_comb
  begin
    case (paddr)
      BLSPC_OFS_CTRL,
      BLSPC_OFS_PTR,
      BLSPC_OFS_DATA,
      BLSPC_OFS_ISSUE,
      BLSPC_OFS_LOCK,
      BLSPC_OFS_STATUS,
      BLSPC_OFS_LATADDR,
      BLSPC_OFS_RDDATA: map_hit = 1'b1;
      default:          map_hit = 1'b0;
    endcase
  end

  // Refused store-program or load-program accesses
  always_comb
  begin
    drop_evt = 1'b0;
    if (spm_go)
    begin
      if (cmd == BLSPC_CMD_ERASE || cmd == BLSPC_CMD_WRITE)
        drop_evt = !spm_ok;
      else if (cmd != BLSPC_CMD_FILL && cmd != BLSPC_CMD_LOCK)
        drop_evt = 1'b1;
    end
    else if (is_lpm && pready)
      drop_evt = !lpm_ok;
  end

  // Pin synchronisers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fuse_s1_r <= 1'b1;
      fuse_s2_r <= 1'b1;
      ce_s1_r   <= 1'b0;
      ce_s2_r   <= 1'b0;
    end
    else
    begin
      fuse_s1_r <= boot_reset_fuse;
      fuse_s2_r <= fuse_s1_r;
      ce_s1_r   <= chip_erase;
      ce_s2_r   <= ce_s1_r;
    end
  end

  // Reset vector follows fuse; fuse has no software path
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reset_vector <= BLSPC_APP_VEC;
    else
      reset_vector <= fuse_s2_r ? BLSPC_APP_VEC : BOOT_START;
  end

  // APB bus
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      prdata  <= 32'h00000000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          BLSPC_OFS_CTRL:    prdata <= {24'h000000, ctrl_r};
          BLSPC_OFS_PTR:     prdata <= {16'h0000, ptr};
          BLSPC_OFS_DATA:    prdata <= {16'h0000, data_r};
          BLSPC_OFS_LOCK:    prdata <= {26'h0000000, boot_lock_field, app_lock_field, 2'h3};
          BLSPC_OFS_STATUS:  prdata <= {24'h000000, drop_cnt_r, 1'b0, intv_boot_r,
                                        1'b0, win_r};
          BLSPC_OFS_LATADDR: prdata <= {16'h0000, lat_addr_r};
          BLSPC_OFS_RDDATA:  prdata <= {24'h000000, rd_byte_r};
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Pointer and data registers; issue also tells section and vector placement
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pointer_high_byte <= 8'h00;
      pointer_low_byte  <= 8'h00;
      data_r            <= 16'h0000;
      intv_boot_r       <= 1'b0;
      exec_boot_r       <= 1'b0;
    end
    else if (wr_acc && pready)
    begin
      if (paddr == BLSPC_OFS_PTR)
      begin
        pointer_high_byte <= pwdata[15:8];
        pointer_low_byte  <= pwdata[7:0];
      end
      if (paddr == BLSPC_OFS_DATA)
        data_r <= pwdata[15:0];
      if (paddr == BLSPC_OFS_ISSUE)
      begin
        intv_boot_r <= pwdata[BLSPC_ISSUE_INTV_BIT];
        exec_boot_r <= from_boot;
      end
    end
  end

  // Command window: store-program must follow within four cycles
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r  <= 8'h00;
      win_r   <= 3'h0;
      state_r <= BLSPC_IDLE;
    end
    else if (wr_acc && pready && paddr == BLSPC_OFS_CTRL)
    begin
      ctrl_r  <= pwdata[7:0];
      win_r   <= BLSPC_WINDOW_CYC;
      state_r <= BLSPC_ARMED;
    end
    else
    begin
      case (state_r)
        BLSPC_IDLE:
          win_r <= 3'h0;
        BLSPC_ARMED:
        begin
          if (win_r == 3'h1 || (is_spm && pready))
          begin
            ctrl_r  <= 8'h00;
            win_r   <= 3'h0;
            state_r <= BLSPC_IDLE;
          end
          else
            win_r <= win_r - 3'h1;
        end
        default:
        begin
          ctrl_r  <= 8'h00;
          win_r   <= 3'h0;
          state_r <= BLSPC_IDLE;
        end
      endcase
    end
  end

  // Lock bits: software may only program (clear to zero); chip erase restores ones
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      app_lock_bit_hi  <= BLSPC_LOCK_RST[1];
      app_lock_bit_lo  <= BLSPC_LOCK_RST[0];
      boot_lock_bit_hi <= BLSPC_LOCK_RST[1];
      boot_lock_bit_lo <= BLSPC_LOCK_RST[0];
    end
    else if (ce_s2_r)
    begin
      app_lock_bit_hi  <= 1'b1;
      app_lock_bit_lo  <= 1'b1;
      boot_lock_bit_hi <= 1'b1;
      boot_lock_bit_lo <= 1'b1;
    end
    else if (spm_go && cmd == BLSPC_CMD_LOCK)
    begin
      // Pointer not consulted here
      app_lock_bit_lo  <= app_lock_bit_lo  & data_r[BLSPC_LKD_APP_LO_BIT];
      app_lock_bit_hi  <= app_lock_bit_hi  & data_r[BLSPC_LKD_APP_HI_BIT];
      boot_lock_bit_lo <= boot_lock_bit_lo & data_r[BLSPC_LKD_BOOT_LO_BIT];
      boot_lock_bit_hi <= boot_lock_bit_hi & data_r[BLSPC_LKD_BOOT_HI_BIT];
    end
  end

  // Flash operations: latched address, strobes one cycle each
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      flash_erase <= 1'b0;
      flash_fill  <= 1'b0;
      flash_write <= 1'b0;
      flash_read  <= 1'b0;
      flash_addr  <= 16'h0000;
      flash_wdata <= 16'h0000;
      lat_addr_r  <= 16'h0000;
    end
    else
    begin
      flash_erase <= 1'b0;
      flash_fill  <= 1'b0;
      flash_write <= 1'b0;
      flash_read  <= 1'b0;
      if (spm_go)
      begin
        if (cmd == BLSPC_CMD_FILL)
        begin
          // Word index only; any order accepted
          flash_fill  <= 1'b1;
          flash_addr  <= {{(16 - WORD_BITS){1'b0}}, ptr[WORD_BITS:1]};
          flash_wdata <= data_r;
        end
        else if ((cmd == BLSPC_CMD_ERASE || cmd == BLSPC_CMD_WRITE) && spm_ok)
        begin
          flash_erase <= cmd == BLSPC_CMD_ERASE;
          flash_write <= cmd == BLSPC_CMD_WRITE;
          lat_addr_r  <= {ptr[15:WORD_BITS + 1], {(WORD_BITS + 1){1'b0}}};
          flash_addr  <= {ptr[15:WORD_BITS + 1], {(WORD_BITS + 1){1'b0}}};
        end
      end
      else if (is_lpm && pready)
      begin
        if (lpm_ok)
        begin
          flash_read <= 1'b1;
          flash_addr <= ptr;
        end
      end
    end
  end

  // Refused access count, wraps
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      drop_cnt_r <= 2'h0;
    else if (drop_evt)
      drop_cnt_r <= drop_cnt_r + 2'h1;
  end

  // Read byte captured from flash one cycle after the read strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rd_byte_r <= 8'h00;
    else if (flash_read)
      rd_byte_r <= flash_rbyte;
  end

  // Interrupt masking when executing from the section without the vectors and that section's bit hi is programmed
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      int_mask <= 1'b0;
    else
      int_mask <= (intv_boot_r && !exec_boot_r && !app_lock_bit_hi)
               || (!intv_boot_r && exec_boot_r && !boot_lock_bit_hi);
  end
endmodule : blspc_top
`default_nettype wire

// ==== dv/blspc_flash_model.sv ====
// Flash array stand-in answering byte reads
`timescale 1ns/1ps
`default_nettype none
module blspc_flash_model (
  input  wire logic        mclk,
  input  wire logic        flash_read,
  input  wire logic [15:0] flash_addr,
  output logic [7:0]       flash_rbyte
);
  logic [7:0] idle_r = 8'h00;
  // Line toggles when no read is in progress
  always_ff @(posedge mclk) idle_r <= ~idle_r;
  assign flash_rbyte = flash_read ? (flash_addr[7:0] ^ 8'h5A) : idle_r;
endmodule : blspc_flash_model
`default_nettype wire

// ==== dv/blspc_props.sv ====
// Checker of strobe, address and reset vector relations
`timescale 1ns/1ps
`default_nettype none
module blspc_props
  import blspc_pkg::*;
#(
  parameter int          WORD_BITS  = 6,
  parameter logic [15:0] BOOT_START = 16'h7000
)(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        boot_reset_fuse,
  input wire logic [15:0] reset_vector,
  input wire logic        flash_erase,
  input wire logic        flash_fill,
  input wire logic        flash_write,
  input wire logic        flash_read,
  input wire logic [15:0] flash_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic iss_spm;
  logic iss_lpm;
  assign iss_spm = psel && penable && pwrite && (paddr == BLSPC_OFS_ISSUE) && pwdata[BLSPC_ISSUE_SPM_BIT]
                   && pwdata[BLSPC_ISSUE_BOOT_BIT];
  assign iss_lpm = psel && penable && pwrite && (paddr == BLSPC_OFS_ISSUE) && pwdata[BLSPC_ISSUE_LPM_BIT];
  vec_app_a:
    assert property (boot_reset_fuse [*6] |=> reset_vector == BLSPC_APP_VEC) else $error("vector not app");
  vec_boot_a:
    assert property (!boot_reset_fuse [*6] |=> reset_vector == BOOT_START) else $error("vector not boot");
  page_align_a:
    assert property (flash_erase || flash_write |-> flash_addr[WORD_BITS:0] == '0) else $error("page unaligned");
  fill_word_a:
    assert property (flash_fill |-> flash_addr[15:WORD_BITS] == '0) else $error("fill index wide");
  spm_cause_a:
    assert property (flash_erase || flash_fill || flash_write |-> $past(iss_spm)) else $error("store without issue");
  read_cause_a:
    assert property (flash_read |-> $past(iss_lpm)) else $error("read without issue");
  fill_single_a:
    assert property (flash_fill |=> !flash_fill) else $error("fill held");
  strobe_onehot_a:
    assert property ($onehot0({flash_erase, flash_fill, flash_write, flash_read})) else $error("strobes overlap");
endmodule : blspc_props
bind blspc_top blspc_props #(.WORD_BITS(WORD_BITS), .BOOT_START(BOOT_START)) i_props (.mclk(mclk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .boot_reset_fuse(boot_reset_fuse),
  .reset_vector(reset_vector), .flash_erase(flash_erase), .flash_fill(flash_fill), .flash_write(flash_write),
  .flash_read(flash_read), .flash_addr(flash_addr));
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the self-program control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import blspc_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, chip_erase, boot_reset_fuse, int_mask;
  logic        flash_erase, flash_fill, flash_write, flash_read;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] reset_vector, flash_addr, flash_wdata, seen_a, p, a;
  logic [7:0]  flash_rbyte, c;
  logic [3:0]  seen_k, s, k;
  int          err_total = 0, checks = 0, cyc = 0, i;
  // Rows: command, pointer, issue bits, expected strobe, expected address
  logic [47:0] rows [8] = '{
    {8'h00, 16'h1235, 4'h3, 4'h1, 16'h1235},
    {8'h03, 16'h1234, 4'h6, 4'h8, 16'h1200}, {8'h01, 16'h1234, 4'h6, 4'h4, 16'h001A},
    {8'h01, 16'h0002, 4'h6, 4'h4, 16'h0001}, {8'h05, 16'h1234, 4'h6, 4'h2, 16'h1200},
    {8'h03, 16'h7080, 4'h6, 4'h8, 16'h7080}, {8'h03, 16'h1234, 4'h4, 4'h0, 16'h0000},
    {8'h00, 16'h0123, 4'h3, 4'h1, 16'h0123}};
  blspc_top #(.WORD_BITS(6), .BOOT_START(16'h7000)) i_blspc_top (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .chip_erase(chip_erase), .boot_reset_fuse(boot_reset_fuse), .reset_vector(reset_vector),
    .int_mask(int_mask), .flash_erase(flash_erase), .flash_fill(flash_fill), .flash_write(flash_write),
    .flash_read(flash_read), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rbyte(flash_rbyte));
  blspc_flash_model i_blspc_flash_model (.mclk(mclk), .flash_read(flash_read), .flash_addr(flash_addr),
    .flash_rbyte(flash_rbyte));
  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    if (ad == 12'h0FC)
      chk("unmapped_err", {31'h0, pslverr}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input logic [7:0] cm, input logic [15:0] pt, input logic [3:0] is);
    apb(1'b1, BLSPC_OFS_PTR, {16'h0, pt});
    apb(1'b1, BLSPC_OFS_CTRL, {24'h0, cm});
    apb(1'b1, BLSPC_OFS_ISSUE, {28'h0, is});
    watch();
  endtask : op
  // Records the flash strobe and its address over the two cycles after an issue
  task automatic watch();
    seen_k = 4'h0;
    repeat (2)
    begin
      @(negedge mclk);
      if ({flash_erase, flash_fill, flash_write, flash_read} != 4'h0)
      begin
        seen_k = {flash_erase, flash_fill, flash_write, flash_read};
        seen_a = flash_addr;
      end
    end
  endtask : watch
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, chip_erase, paddr, pwdata} = '0;
    boot_reset_fuse = 1'b1;
    seen_k = 4'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, BLSPC_OFS_LOCK, 32'h0);
    chk("lock_rst", rd, 32'h3F);
    chk("vector_app", {16'h0, reset_vector}, 32'h0);
    boot_reset_fuse <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("vector_boot", {16'h0, reset_vector}, 32'h7000);
    for (i = 0; i < 8; i++)
    begin
      {c, p, s, k, a} = rows[i];
      op(c, p, s);
      chk("strobe", {28'h0, seen_k}, {28'h0, k});
      if (k != 4'h0)
        chk("flash_addr", {16'h0, seen_a}, {16'h0, a});
    end
    apb(1'b0, BLSPC_OFS_RDDATA, 32'h0);
    chk("read_byte", rd, 32'h79);
    apb(1'b0, BLSPC_OFS_LATADDR, 32'h0);
    chk("latched", rd, 32'h7080);
    apb(1'b1, BLSPC_OFS_CTRL, 32'h03);
    repeat (6) @(posedge mclk);
    apb(1'b1, BLSPC_OFS_ISSUE, 32'h6);
    watch();
    chk("late_issue", {28'h0, seen_k}, 32'h0);
    apb(1'b1, BLSPC_OFS_DATA, 32'h13);
    op(BLSPC_CMD_FILL, 16'h0002, 4'h6);
    chk("fill_strobe", {28'h0, seen_k}, 32'h4);
    chk("fill_data", {16'h0, flash_wdata}, 32'h13);
    op(BLSPC_CMD_LOCK, 16'h0123, 4'h6);
    apb(1'b0, BLSPC_OFS_LOCK, 32'h0);
    chk("lock_set", rd, 32'h13);
    chk("mask_boot", {31'h0, int_mask}, 32'h1);
    apb(1'b1, BLSPC_OFS_ISSUE, 32'h0);
    repeat (2) @(negedge mclk);
    chk("mask_none", {31'h0, int_mask}, 32'h0);
    apb(1'b1, BLSPC_OFS_ISSUE, 32'h8);
    repeat (2) @(negedge mclk);
    chk("mask_app", {31'h0, int_mask}, 32'h1);
    op(BLSPC_CMD_ERASE, 16'h1234, 4'h6);
    chk("locked_erase", {28'h0, seen_k}, 32'h0);
    op(8'h00, 16'h1235, 4'h3);
    chk("locked_read", {28'h0, seen_k}, 32'h0);
    apb(1'b0, BLSPC_OFS_STATUS, 32'h0);
    chk("drop_count", rd, 32'h80);
    chip_erase <= 1'b1;
    repeat (4) @(posedge mclk);
    chip_erase <= 1'b0;
    repeat (4) @(posedge mclk);
    apb(1'b0, BLSPC_OFS_LOCK, 32'h0);
    chk("lock_clear", rd, 32'h3F);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("vector_rst", {16'h0, reset_vector}, 32'h7000);
    apb(1'b0, BLSPC_OFS_STATUS, 32'h0);
    chk("status_rst", rd, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    final_report();
  end
endmodule : testbench
`default_nettype wire
